// File: rtl/ath_alarm_cmp.sv
// Per-channel high and low alarm comparator with shared deadband.
`timescale 1ns/10ps

module ath_alarm_cmp
    import ath_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic [ATH_LIMIT_W-1:0] sample_data,
    input wire logic [ATH_BYTE_W-1:0] chan_alarm_deadband,
    input wire logic [ATH_LIMIT_W-1:0] chan_high_limit,
    input wire logic [ATH_LIMIT_W-1:0] chan_low_limit,
    output logic alarm_high,
    output logic alarm_low
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic high;   // High alarm active
        logic low;    // Low alarm active
    } ath_cmp_state_type;

    ath_cmp_state_type state_r;        // Registered state
    ath_cmp_state_type state_nxt;      // Next state
    logic [ATH_LIMIT_W:0] band_wide;   // Deadband widened to one bit above the limit size
    logic [ATH_LIMIT_W:0] high_release; // Level below which high clears
    logic [ATH_LIMIT_W:0] low_release;  // Level above which low clears
    logic [ATH_LIMIT_W:0] sample_wide;  // Sample widened for comparison

    // ------------------------------------------------------------------
    // Release levels
    // ------------------------------------------------------------------
    // One deadband serves both directions; the low limit plus the band
    // may pass the top of the range, so one extra bit keeps it exact
    always_comb begin
        band_wide = {9'h000, chan_alarm_deadband};
        sample_wide = {1'b0, sample_data};
        // Clamp at zero so a band larger than the limit never wraps
        if ({1'b0, chan_high_limit} < band_wide) begin
            high_release = 17'h00000;
        end else begin
            high_release = {1'b0, chan_high_limit} - band_wide;
        end
        low_release = {1'b0, chan_low_limit} + band_wide;
    end

    // ------------------------------------------------------------------
    // Alarm flags, updated only on a new sample
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        if (sample_valid) begin
            // High alarm sets above the limit, clears below the band
            if (sample_data > chan_high_limit) begin
                state_nxt.high = 1'b1;
            end else if (sample_wide < high_release) begin
                state_nxt.high = 1'b0;
            end
            // Low alarm sets below the limit, clears above the band
            if (sample_data < chan_low_limit) begin
                state_nxt.low = 1'b1;
            end else if (sample_wide > low_release) begin
                state_nxt.low = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign alarm_high = state_r.high;
    assign alarm_low = state_r.low;

endmodule : ath_alarm_cmp

// File: rtl/ath_bank.sv
// Alarm threshold and deadband register bank with APB access.
`timescale 1ns/10ps

module ath_bank
    import ath_pkg::*;
#(
    parameter int NUM_CHAN = ATH_MAX_CHAN,
    parameter int ADDR_W = ATH_APB_ADDR_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [ATH_APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ATH_APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [ATH_CHAN_W-1:0] sample_chan,
    input wire logic [ATH_LIMIT_W-1:0] sample_data,
    output logic [ATH_MAX_CHAN-1:0] alarm_high,
    output logic [ATH_MAX_CHAN-1:0] alarm_low
);

    // ------------------------------------------------------------------
    // Index decode
    // ------------------------------------------------------------------
    // Maps a register index to its channel and kind; only channels that
    // exist in this variant answer
    function automatic ath_decode_type ath_decode(
        input logic [ATH_IDX_W-1:0] idx,
        input int chans
    );
        ath_decode_type dec;
        logic [ATH_IDX_W-1:0] base;
        logic [ATH_IDX_W-1:0] offs;
        dec.hit = 1'b0;
        dec.chan = '0;
        dec.field = ATH_FLD_NONE;
        base = ATH_CH0_DEADBAND_IDX;
        offs = '0;
        // Walk the channel groups, five registers each
        for (int c = 0; c < ATH_MAX_CHAN; c++) begin
            if (c < chans && idx >= base
                    && idx < base + ATH_REGS_PER_CHAN) begin
                offs = idx - base;
                dec.hit = 1'b1;
                dec.chan = ATH_CHAN_W'(c);
                dec.field = ath_field_type'(offs[2:0]);
            end
            base = base + ATH_REGS_PER_CHAN;
        end
        // Alarm flag status registers
        if (idx == ATH_HIGH_FLAGS_IDX) begin
            dec.hit = 1'b1;
            dec.field = ATH_FLD_HIGH_FLAGS;
        end else if (idx == ATH_LOW_FLAGS_IDX) begin
            dec.hit = 1'b1;
            dec.field = ATH_FLD_LOW_FLAGS;
        end
        return dec;
    endfunction : ath_decode

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ATH_MAX_CHAN-1:0][ATH_BYTE_W-1:0] deadband;   // Deadbands
        logic [ATH_MAX_CHAN-1:0][ATH_BYTE_W-1:0] high_upper; // High upper
        logic [ATH_MAX_CHAN-1:0][ATH_BYTE_W-1:0] high_lower; // High lower
        logic [ATH_MAX_CHAN-1:0][ATH_BYTE_W-1:0] low_upper;  // Low upper
        logic [ATH_MAX_CHAN-1:0][ATH_BYTE_W-1:0] low_lower;  // Low lower
        logic [ATH_APB_DATA_W-1:0] prdata;                   // Read data
        logic pready;                                        // Access ready
        logic pslverr;                                       // Access error
    } ath_bank_state_type;

    ath_bank_state_type state_r;     // Registered state
    ath_bank_state_type state_nxt;   // Next state
    ath_decode_type dec;             // Decode of the current address
    logic addr_ok;                   // Aligned and inside the index range
    logic setup_phase;               // First cycle of a transfer
    logic write_done;                // Write completes at this edge
    logic [ATH_BYTE_W-1:0] read_byte; // Byte selected for a read
    logic [ATH_MAX_CHAN-1:0] flag_high; // High alarm flags
    logic [ATH_MAX_CHAN-1:0] flag_low;  // Low alarm flags
    logic [ATH_MAX_CHAN-1:0][ATH_LIMIT_W-1:0] high_limit; // Whole limits
    logic [ATH_MAX_CHAN-1:0][ATH_LIMIT_W-1:0] low_limit;  // Whole limits

    // ------------------------------------------------------------------
    // Address and phase decode
    // ------------------------------------------------------------------
    always_comb begin
        addr_ok = (paddr[1:0] == ATH_WORD_ALIGN)
            && (paddr >> (ATH_IDX_W + 2)) == '0;
        dec = ath_decode(paddr[ATH_IDX_W+1:2], NUM_CHAN);
        if (!addr_ok) begin
            dec.hit = 1'b0;
        end
        setup_phase = psel && !penable;
        write_done = psel && penable && state_r.pready && pwrite;
    end

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    always_comb begin
        read_byte = '0;
        unique case (dec.field)
            ATH_FLD_DEADBAND: read_byte = state_r.deadband[dec.chan];
            ATH_FLD_HIGH_UPPER: read_byte = state_r.high_upper[dec.chan];
            ATH_FLD_HIGH_LOWER: read_byte = state_r.high_lower[dec.chan];
            ATH_FLD_LOW_UPPER: read_byte = state_r.low_upper[dec.chan];
            ATH_FLD_LOW_LOWER: read_byte = state_r.low_lower[dec.chan];
            ATH_FLD_HIGH_FLAGS: read_byte = flag_high;
            ATH_FLD_LOW_FLAGS: read_byte = flag_low;
            ATH_FLD_NONE: read_byte = '0;
            // Codes five to seven never come from a channel group
            default: read_byte = '0;
        endcase
        if (!dec.hit) begin
            read_byte = '0;
        end
    end

    // ------------------------------------------------------------------
    // Next state: bus answer and register writes
    // ------------------------------------------------------------------
    // The answer is prepared in the setup cycle so that prdata, pready
    // and pslverr all come straight from flip-flops
    always_comb begin
        state_nxt = state_r;
        state_nxt.pready = setup_phase;
        if (setup_phase) begin
            state_nxt.prdata = {24'h000000, read_byte};
            // Unmapped, misaligned, and status writes are refused
            state_nxt.pslverr = !dec.hit || (pwrite
                && (dec.field == ATH_FLD_HIGH_FLAGS
                || dec.field == ATH_FLD_LOW_FLAGS));
        end else if (!psel) begin
            state_nxt.prdata = '0;
            state_nxt.pslverr = 1'b0;
        end
        // Write lands at the access edge; only byte lane 0 is stored
        if (write_done && dec.hit && pstrb[0]) begin
            unique case (dec.field)
                ATH_FLD_DEADBAND:
                    state_nxt.deadband[dec.chan] = pwdata[7:0];
                ATH_FLD_HIGH_UPPER:
                    state_nxt.high_upper[dec.chan] = pwdata[7:0];
                ATH_FLD_HIGH_LOWER:
                    state_nxt.high_lower[dec.chan] = pwdata[7:0];
                ATH_FLD_LOW_UPPER:
                    state_nxt.low_upper[dec.chan] = pwdata[7:0];
                ATH_FLD_LOW_LOWER:
                    state_nxt.low_lower[dec.chan] = pwdata[7:0];
                ATH_FLD_HIGH_FLAGS: state_nxt.pslverr = 1'b1;
                ATH_FLD_LOW_FLAGS: state_nxt.pslverr = 1'b1;
                ATH_FLD_NONE: state_nxt.pslverr = 1'b1;
                // Unused kind codes store nothing and raise pslverr
                default: state_nxt.pslverr = 1'b1;
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r.deadband <= {ATH_MAX_CHAN{ATH_DEADBAND_RST}};
            state_r.high_upper <= {ATH_MAX_CHAN{ATH_HIGH_LIMIT_RST}};
            state_r.high_lower <= {ATH_MAX_CHAN{ATH_HIGH_LIMIT_RST}};
            state_r.low_upper <= {ATH_MAX_CHAN{ATH_LOW_LIMIT_RST}};
            state_r.low_lower <= {ATH_MAX_CHAN{ATH_LOW_LIMIT_RST}};
            state_r.prdata <= '0;
            state_r.pready <= 1'b0;
            state_r.pslverr <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel comparators
    // ------------------------------------------------------------------
    // Channels absent from the smaller variant never see a sample, so
    // their flags stay clear
    for (genvar g = 0; g < ATH_MAX_CHAN; g++) begin : g_chan
        logic chan_sample; // Sample belongs to this channel
        assign high_limit[g] = {state_r.high_upper[g],
            state_r.high_lower[g]};
        assign low_limit[g] = {state_r.low_upper[g], state_r.low_lower[g]};
        assign chan_sample = sample_valid && (g < NUM_CHAN)
            && (sample_chan == ATH_CHAN_W'(g));
        ath_alarm_cmp u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(chan_sample),
            .sample_data(sample_data),
            .chan_alarm_deadband(state_r.deadband[g]),
            .chan_high_limit(high_limit[g]),
            .chan_low_limit(low_limit[g]),
            .alarm_high(flag_high[g]),
            .alarm_low(flag_low[g])
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = state_r.prdata;
    assign pready = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign alarm_high = flag_high;
    assign alarm_low = flag_low;

endmodule : ath_bank

// File: rtl/ath_pkg.sv
// Constants and types shared by the alarm threshold register bank.
package ath_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int ATH_MAX_CHAN = 8;       // Channels in the larger variant
    localparam int ATH_SMALL_CHAN = 4;     // Channels in the smaller variant
    localparam int ATH_BYTE_W = 8;         // Width of every register
    localparam int ATH_LIMIT_W = 16;       // Width of a whole threshold
    localparam int ATH_CHAN_W = 3;         // Width of a channel number
    localparam int ATH_IDX_W = 8;          // Width of a register index
    localparam int ATH_APB_ADDR_W = 12;    // APB address width
    localparam int ATH_APB_DATA_W = 32;    // APB data width

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] ATH_CH0_DEADBAND_IDX = 8'h15;
    localparam logic [7:0] ATH_CH0_HIGH_UPPER_IDX = 8'h16;
    localparam logic [7:0] ATH_CH0_HIGH_LOWER_IDX = 8'h17;
    localparam logic [7:0] ATH_CH0_LOW_UPPER_IDX = 8'h18;
    localparam logic [7:0] ATH_CH0_LOW_LOWER_IDX = 8'h19;
    localparam logic [7:0] ATH_LAST_CHAN_IDX = 8'h3C;
    localparam logic [7:0] ATH_REGS_PER_CHAN = 8'h05;
    localparam logic [7:0] ATH_HIGH_FLAGS_IDX = 8'h40;
    localparam logic [7:0] ATH_LOW_FLAGS_IDX = 8'h41;
    localparam logic [1:0] ATH_WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ATH_DEADBAND_RST = 8'h00;
    localparam logic [7:0] ATH_HIGH_LIMIT_RST = 8'h01;
    localparam logic [7:0] ATH_LOW_LIMIT_RST = 8'h00;

    // ------------------------------------------------------------------
    // Register kinds: one channel group in address order, then flags and none
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ATH_FLD_DEADBAND,
        ATH_FLD_HIGH_UPPER,
        ATH_FLD_HIGH_LOWER,
        ATH_FLD_LOW_UPPER,
        ATH_FLD_LOW_LOWER,
        ATH_FLD_HIGH_FLAGS,
        ATH_FLD_LOW_FLAGS,
        ATH_FLD_NONE
    } ath_field_type;

    // Result of decoding one register index
    typedef struct packed {
        logic hit;
        logic [ATH_CHAN_W-1:0] chan;
        ath_field_type field;
    } ath_decode_type;

endpackage : ath_pkg

// File: verif/ath_apb_host.sv
// APB host model that drives the register bank from the far side.
`timescale 1ns/10ps
module ath_apb_host
    import ath_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ATH_APB_ADDR_W-1:0] paddr,
    output logic [ATH_APB_DATA_W-1:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [ATH_APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end

    // One transfer: setup, then access held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // No time limit here; pready or the bench watchdog ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ath_apb_host

// File: verif/ath_bank_asserts.sv
// Concurrent checks on the ports of the alarm threshold bank.
`timescale 1ns/10ps
module ath_bank_asserts
    import ath_pkg::*;
#(
    parameter int NUM_CHAN = ATH_MAX_CHAN,
    parameter int ADDR_W = ATH_APB_ADDR_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [ATH_APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [ATH_APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic [ATH_CHAN_W-1:0] sample_chan,
    input wire logic [ATH_LIMIT_W-1:0] sample_data,
    input wire logic [ATH_MAX_CHAN-1:0] alarm_high,
    input wire logic [ATH_MAX_CHAN-1:0] alarm_low
);
    // Last index of the channel groups present
    localparam int LAST_IDX = 8'h15 + 5 * NUM_CHAN - 1;
    logic setup; // Setup cycle of a transfer
    logic [7:0] sidx; // Register index on the bus
    logic align; // Aligned word with upper address bits clear
    assign setup = psel && !penable;
    assign sidx = paddr[9:2];
    assign align = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    upper_zero_a: assert property (pready && !pwrite
        |-> prdata[31:8] == 24'h000000)
        else $error("read data above byte not zero");
    map_ok_a: assert property (setup && align && sidx >= 8'h15
        && sidx <= LAST_IDX |=> pready && !pslverr)
        else $error("mapped register refused");
    misalign_err_a: assert property (setup && !align |=> pslverr)
        else $error("misaligned access accepted");
    beyond_err_a: assert property (setup && align && sidx > LAST_IDX
        && sidx < 8'h40 |=> pslverr)
        else $error("absent register accepted");
    flag_wr_err_a: assert property (setup && pwrite
        && (sidx == 8'h40 || sidx == 8'h41) |=> pslverr)
        else $error("flag write accepted");
    alarm_hold_a: assert property (!sample_valid |=> $stable(alarm_high)
        && $stable(alarm_low))
        else $error("alarm moved without sample");
    other_chan_a: assert property (sample_valid |=>
        (((alarm_high ^ $past(alarm_high)) | (alarm_low ^ $past(alarm_low)))
        & ~(8'h01 << $past(sample_chan))) == 8'h00)
        else $error("alarm of other channel moved");
    flag_read_a: assert property (setup && !pwrite && paddr == 'h100
        |=> prdata[7:0] == $past(alarm_high))
        else $error("high flag read wrong");
    // Flags of channels absent from this variant never rise
    absent_flag_a: assert property (
        ((alarm_high | alarm_low) >> NUM_CHAN) == 8'h00)
        else $error("absent channel flag set");
endmodule : ath_bank_asserts

// File: verif/testbench.sv
// Self-checking bench for the alarm threshold register bank.
`timescale 1ns/10ps
module testbench;
    import ath_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] sample_chan;
    logic [15:0] sample_data;
    logic [7:0] alarm_high, alarm_low;
    int n_mismatch, cmp_count;
    // Four-channel variant on a bus of its own, sharing the sample port
    logic s_psel, s_penable, s_pwrite, s_pready, s_pslverr;
    logic [11:0] s_paddr;
    logic [31:0] s_pwdata, s_prdata;
    logic [3:0] s_pstrb;
    logic [7:0] s_alarm_high, s_alarm_low;

    ath_bank #(.NUM_CHAN(8), .ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_chan(sample_chan), .sample_data(sample_data),
        .alarm_high(alarm_high), .alarm_low(alarm_low));
    ath_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ath_bank #(.NUM_CHAN(4), .ADDR_W(12)) dut_small (.pclk(pclk),
        .presetn(presetn), .psel(s_psel), .penable(s_penable),
        .pwrite(s_pwrite), .paddr(s_paddr), .pwdata(s_pwdata),
        .pstrb(s_pstrb), .prdata(s_prdata), .pready(s_pready),
        .pslverr(s_pslverr), .sample_valid(sample_valid),
        .sample_chan(sample_chan), .sample_data(sample_data),
        .alarm_high(s_alarm_high), .alarm_low(s_alarm_low));
    ath_apb_host host_small (.pclk(pclk), .psel(s_psel),
        .penable(s_penable), .pwrite(s_pwrite), .paddr(s_paddr),
        .pwdata(s_pwdata), .pstrb(s_pstrb), .prdata(s_prdata),
        .pready(s_pready), .pslverr(s_pslverr));

    // 100 MHz clock
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // Compare and count
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Index of register k of channel c
    function automatic logic [7:0] ix(int c, int k);
        return 8'(8'h15 + 5 * c + k);
    endfunction : ix

    task automatic wr(logic [7:0] i, logic [7:0] d, logic [3:0] s, logic ee);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, {2'h0, i, 2'h0}, {24'hA5C3E1, d}, s, q, e);
        chk("write error", e, ee);
    endtask : wr

    task automatic rd(logic [7:0] i, logic [31:0] x, logic ee);
        logic [31:0] q;
        logic e;
        host.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, 4'h0, q, e);
        chk("read data", q, x);
        chk("read error", e, ee);
    endtask : rd

    // One sample, then both flag vectors against the expectation
    task automatic smp(logic [2:0] c, logic [15:0] d, logic h, logic l);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_chan <= c;
        sample_data <= d;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_data <= ~d;
        @(negedge pclk);
        chk("alarm high", alarm_high, 8'(h) << c);
        chk("alarm low", alarm_low, 8'(l) << c);
    endtask : smp

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic t_reset();
        chk("flags after reset", {alarm_high, alarm_low}, 16'h0);
        for (int c = 0; c < 8; c++) begin
            rd(ix(c, 0), 32'h0, 1'b0);
            rd(ix(c, 1), 32'h1, 1'b0);
            rd(ix(c, 2), 32'h1, 1'b0);
        end
    endtask : t_reset

    task automatic t_rw();
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 5; k++)
                wr(ix(c, k), 8'(8'h30 + 5 * c + k), 4'h1, 1'b0);
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 5; k++)
                rd(ix(c, k), 32'(8'h30 + 5 * c + k), 1'b0);
        wr(ix(0, 0), 8'hEE, 4'hE, 1'b0);
        rd(ix(0, 0), 32'h30, 1'b0);
    endtask : t_rw

    task automatic t_bad();
        logic [31:0] q;
        logic e;
        rd(8'h3D, 32'h0, 1'b1);
        rd(8'h14, 32'h0, 1'b1);
        wr(8'h40, 8'hFF, 4'hF, 1'b1);
        rd(8'h40, 32'h0, 1'b0);
        host.xfer(1'b0, 12'h055, 32'h0, 4'h0, q, e);
        chk("misaligned", e, 1'b1);
        host.xfer(1'b0, 12'h454, 32'h0, 4'h0, q, e);
        chk("upper address", e, 1'b1);
    endtask : t_bad

    // Channel 2: high limit AAFFh, low limit 1000h, widest deadband
    task automatic t_alarm();
        wr(ix(2, 1), 8'hAA, 4'h1, 1'b0);
        wr(ix(2, 2), 8'hFF, 4'h1, 1'b0);
        wr(ix(2, 0), 8'hFF, 4'h1, 1'b0);
        wr(ix(2, 3), 8'h10, 4'h1, 1'b0);
        wr(ix(2, 4), 8'h00, 4'h1, 1'b0);
        smp(3'd2, 16'hAB00, 1'b1, 1'b0);
        rd(8'h40, 32'h4, 1'b0);
        smp(3'd2, 16'hAA00, 1'b1, 1'b0);
        smp(3'd2, 16'hA9FF, 1'b0, 1'b0);
        smp(3'd2, 16'h0FFF, 1'b0, 1'b1);
        rd(8'h41, 32'h4, 1'b0);
        smp(3'd2, 16'h10FF, 1'b0, 1'b1);
        smp(3'd2, 16'h1100, 1'b0, 1'b0);
        wr(ix(2, 0), 8'h00, 4'h1, 1'b0);
        smp(3'd2, 16'hAB00, 1'b1, 1'b0);
        smp(3'd2, 16'hAAFE, 1'b0, 1'b0);
    endtask : t_alarm

    // Four-channel variant: channel 3 answers, channel 4 and up do not
    task automatic t_small();
        logic [31:0] q;
        logic e;
        host_small.xfer(1'b1, 12'h090, 32'h5A, 4'h1, q, e);
        chk("small write error", e, 1'b0);
        host_small.xfer(1'b0, 12'h090, 32'h0, 4'h0, q, e);
        chk("small read data", q, 32'h5A);
        host_small.xfer(1'b1, 12'h0A4, 32'h5A, 4'h1, q, e);
        chk("small absent write", e, 1'b1);
        host_small.xfer(1'b0, 12'h0A4, 32'h0, 4'h0, q, e);
        chk("small absent data", q, 32'h0);
        chk("small absent error", e, 1'b1);
        // Channel 5 limits 4A4Bh and 4C4Dh in the large bank only
        smp(3'd5, 16'hFFFF, 1'b1, 1'b0);
        chk("small absent flags", {s_alarm_high[7:4], s_alarm_low[7:4]},
            8'h00);
    endtask : t_small

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // Main sequence, with a second reset in mid-run
    initial begin
        presetn = 1'b0;
        sample_valid = 1'b0;
        sample_chan = 3'h0;
        sample_data = 16'h0;
        n_mismatch = 0;
        cmp_count = 0;
        do_reset();
        t_reset();
        t_rw();
        t_bad();
        t_alarm();
        t_small();
        do_reset();
        t_reset();
        wrap_up();
    end

    // Watchdog
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule : testbench

bind ath_bank ath_bank_asserts #(.NUM_CHAN(NUM_CHAN), .ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data), .alarm_high(alarm_high),
    .alarm_low(alarm_low));
